// ### rtl/bsr_supervisor_regs.sv
// supervisor register banks reached through the host command mailbox
// assumes host strobes on clk; supply pins are asynchronous; other inputs are on clk
//
// Overview of operation
// - port control bits 3/2 disable serial port b/a when set.
// - port control bits 1/0 switch port b/a +5 V supply on.
// - bit 5 requests firmware settings wipe at next restart.
// - policy bits 4-3: stay off, keep running, power once, reserved.
// - policy writable only if a button is power or lamp test, else keep running.
// - bits 7-4 indicator button, 3-0 recessed button; disabled, lamp, power, reset.
// - strings return one byte per read, zero ends and rewinds.
// - serial text at 0x50, product_type_text text 0x51, build option text 0x52.
// - expansion code low 0x70, high 0x71; absent reads 0xffff.
// - health values are 32-bit little-endian from the listed address.
// - reading the lowest byte captures the upper three bytes.
// - temperatures in millikelvin, rails in millivolts; core 0x00, 12 V 0x34.
// - watchdog event word non-zero after expiry since sleep or reset.
// - excess current word is a bitmask, video 0x1 to internal usb 0x10.
// - reading time-code word 0x00 captures all time-code words.
// - bit 31 of each time-code word shows a good decode.
// - seconds word packs stream bits into 25-17, 16-8, 7-0.
// - day word has hundredths in 30-24 and stream bits in 17-0.
// - control word packs stream bits into 26-18, 17-9, 8-0.
// - binary seconds word packs stream bits into 17-9, 8-0.
// - supply state: healthy bit 1, fitted bit 0; at 0x00 and 0x80.
// - supply strings read zero at end or when supply not fitted.
// - host sends read command, then address; byte returns in output buffer.
`timescale 1ns/1ns
`include "bsr_params.svh"
module bsr_supervisor_regs #(
	parameter int TEXT_LEN = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic hostWrite,
	input wire bsr_pkg::bsr_host_wr_t hostWr,
	input wire logic hostReadOut,
	output logic [7:0] outByte_r,
	output logic outFull_r,
	output logic inFull_r,
	output logic lastWasCmd_r,
	output bsr_pkg::bsr_state_t mailboxState_r,
	output logic portBDisable_r,
	output logic portADisable_r,
	output logic portBSupplyOn_r,
	output logic portASupplyOn_r,
	output logic firmwareSettingsWipe_r,
	output logic [1:0] processorPowerPolicy_r,
	output logic [3:0] indicatorButtonFunction_r,
	output logic [3:0] recessedButtonFunction_r,
	input wire logic [2:0][TEXT_LEN*8-1:0] unitText,
	input wire logic [3:0][TEXT_LEN*8-1:0] supplyText,
	input wire logic [3:0] supplyPin,
	input wire logic [15:0] expansionCode,
	input wire logic expansionFitted,
	input wire logic [11:0][31:0] healthSample,
	input wire logic watchdogExpired,
	input wire logic sleepEntered,
	input wire logic [4:0] excessCurrent,
	input wire bsr_pkg::bsr_timecode_t timecode
);
	localparam int NDIAG = `BSR_DIAG_COUNT;
	localparam logic [NDIAG*8-1:0] DIAG_OFFS = `BSR_DIAG_OFFS;

	bsr_pkg::bsr_host_wr_t inReq_r;
	logic haveAddr_r;
	logic [1:0] bank_r;
	logic [7:0] addr_r;
	logic proceed;
	logic doRead;
	logic doWrite;
	logic [7:0] readByte;
	logic policyWritable;
	logic watchdogFlag_r;
	logic [3:0] supplyA_r;
	logic [3:0] supplyB_r;
	logic [3:0] supplyC_r;
	logic [3:0] supplyState_r;
	logic [NDIAG-1:0][31:0] diagLive;
	logic [NDIAG-1:0][23:0] diagHeld_r;
	logic [3:0][31:0] tcLive;
	logic [3:0][31:0] tcHeld_r;
	logic [6:0] textTake;
	logic [6:0][7:0] textByte;
	logic [6:0] textFitted;
	logic diagHit;
	logic [3:0] diagIdx;

	// mailbox work happens only once the output buffer is free
	assign proceed = inFull_r && !outFull_r;
	assign doRead = proceed && !inReq_r.isCmd && mailboxState_r == bsr_pkg::BSR_READ;
	assign doWrite = proceed && !inReq_r.isCmd && mailboxState_r == bsr_pkg::BSR_WRITE
		&& haveAddr_r && bank_r == `BSR_BANK_CFG;

	// input buffer; a second write before service overwrites the first
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			inReq_r <= '0;
			inFull_r <= 1'b0;
			lastWasCmd_r <= 1'b0;
		end
		else if (hostWrite)
		begin
			inReq_r <= hostWr;
			inFull_r <= 1'b1;
			lastWasCmd_r <= hostWr.isCmd;
		end
		else if (proceed)
			inFull_r <= 1'b0;
	end

	// command and address sequencing
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			mailboxState_r <= bsr_pkg::BSR_IDLE;
			bank_r <= `BSR_BANK_CFG;
			haveAddr_r <= 1'b0;
			addr_r <= 8'h00;
		end
		else if (proceed && inReq_r.isCmd)
		begin
			haveAddr_r <= 1'b0;
			bank_r <= inReq_r.data[1:0];
			if (inReq_r.data == `BSR_CMD_ABORT)
				mailboxState_r <= bsr_pkg::BSR_IDLE;
			else if (mailboxState_r == bsr_pkg::BSR_ERROR)
				mailboxState_r <= bsr_pkg::BSR_ERROR;
			else if (inReq_r.data[7:2] == `BSR_CMD_WR_GRP)
				mailboxState_r <= bsr_pkg::BSR_WRITE;
			else if (inReq_r.data[7:2] == `BSR_CMD_RD_GRP)
				mailboxState_r <= bsr_pkg::BSR_READ;
			else
				mailboxState_r <= bsr_pkg::BSR_ERROR;
		end
		else if (proceed)
		begin
			unique case (mailboxState_r)
				bsr_pkg::BSR_IDLE: mailboxState_r <= bsr_pkg::BSR_ERROR;
				bsr_pkg::BSR_ERROR: mailboxState_r <= bsr_pkg::BSR_ERROR;
				bsr_pkg::BSR_READ: mailboxState_r <= bsr_pkg::BSR_IDLE;
				bsr_pkg::BSR_WRITE:
				begin
					haveAddr_r <= 1'b1;
					addr_r <= inReq_r.data;
					if (haveAddr_r)
						mailboxState_r <= bsr_pkg::BSR_IDLE;
				end
			endcase
		end
	end

	// output buffer; the host read clears, a new answer sets and wins
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			outByte_r <= 8'h00;
			outFull_r <= 1'b0;
		end
		else if (doRead)
		begin
			outByte_r <= readByte;
			outFull_r <= 1'b1;
		end
		else if (hostReadOut)
			outFull_r <= 1'b0;
	end

	// a button on power or lamp test unlocks the policy field
	assign policyWritable = indicatorButtonFunction_r == `BSR_BTN_LAMP
		|| indicatorButtonFunction_r == `BSR_BTN_POWER
		|| recessedButtonFunction_r == `BSR_BTN_LAMP
		|| recessedButtonFunction_r == `BSR_BTN_POWER;

	// configuration writes
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			{portBDisable_r, portADisable_r, portBSupplyOn_r, portASupplyOn_r}
				<= `BSR_PORT_CTRL_RST;
			firmwareSettingsWipe_r <= 1'(`BSR_POLICY_REG_RST >> `BSR_WIPE_BIT);
			processorPowerPolicy_r <= 2'(`BSR_POLICY_REG_RST >> `BSR_POLICY_LSB);
			{indicatorButtonFunction_r, recessedButtonFunction_r} <= `BSR_BUTTON_RST;
		end
		else
		begin
			if (doWrite && addr_r == `BSR_ADDR_PORT_CTRL)
			begin
				portBDisable_r <= inReq_r.data[`BSR_PORT_B_DIS_BIT];
				portADisable_r <= inReq_r.data[`BSR_PORT_A_DIS_BIT];
				portBSupplyOn_r <= inReq_r.data[`BSR_PORT_B_PWR_BIT];
				portASupplyOn_r <= inReq_r.data[`BSR_PORT_A_PWR_BIT];
			end
			if (doWrite && addr_r == `BSR_ADDR_POLICY)
				firmwareSettingsWipe_r <= inReq_r.data[`BSR_WIPE_BIT];
			// reserved policy code is dropped, not stored
			if (!policyWritable)
				processorPowerPolicy_r <= `BSR_POLICY_KEEP;
			else if (doWrite && addr_r == `BSR_ADDR_POLICY
				&& inReq_r.data[`BSR_POLICY_LSB +: 2] != `BSR_POLICY_RSVD)
				processorPowerPolicy_r <= inReq_r.data[`BSR_POLICY_LSB +: 2];
			if (doWrite && addr_r == `BSR_ADDR_BUTTON)
				{indicatorButtonFunction_r, recessedButtonFunction_r}
					<= inReq_r.data;
		end
	end

	// supply pins: three stages, accept once stages two and three agree
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			supplyA_r <= 4'h0;
			supplyB_r <= 4'h0;
			supplyC_r <= 4'h0;
			supplyState_r <= 4'h0;
		end
		else
		begin
			supplyA_r <= supplyPin;
			supplyB_r <= supplyA_r;
			supplyC_r <= supplyB_r;
			for (int i = 0; i < 4; i++)
				if (supplyB_r[i] == supplyC_r[i])
					supplyState_r[i] <= supplyC_r[i];
		end
	end

	// sticky watchdog event; a new expiry wins over the sleep clear
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			watchdogFlag_r <= 1'b0;
		else if (watchdogExpired)
			watchdogFlag_r <= 1'b1;
		else if (sleepEntered)
			watchdogFlag_r <= 1'b0;
	end

	// live health words; units are those of the sensor feed
	assign diagLive[11:0] = healthSample;
	assign diagLive[12] = {31'h0, watchdogFlag_r};
	assign diagLive[13] = {27'h0, excessCurrent};

	// live time-code words, reserved bits zero
	assign tcLive[0] = {timecode.good, 5'h0, timecode.secMinHour};
	assign tcLive[1] = {timecode.good, timecode.hundredths, 6'h0, timecode.days};
	assign tcLive[2] = {timecode.good, 4'h0, timecode.control};
	assign tcLive[3] = {timecode.good, 13'h0, timecode.binarySec};

	// health word lookup by word-aligned address
	always_comb
	begin
		diagHit = 1'b0;
		diagIdx = 4'h0;
		for (int i = 0; i < NDIAG; i++)
			if (DIAG_OFFS[i*8 +: 8] == {inReq_r.data[7:2], 2'b00})
			begin
				diagHit = 1'b1;
				diagIdx = 4'(i);
			end
	end

	// reading byte 0 freezes bytes 1-3 of that word only
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			diagHeld_r <= '0;
		else if (doRead && bank_r == `BSR_BANK_DIAG && diagHit && inReq_r.data[1:0] == 2'h0)
			diagHeld_r[diagIdx] <= diagLive[diagIdx][31:8];
	end

	// reading the first time-code byte freezes all four words
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			tcHeld_r <= '0;
		else if (doRead && bank_r == `BSR_BANK_TC && inReq_r.data == `BSR_ADDR_TC_FIRST)
			tcHeld_r <= tcLive;
	end

	// string cursors: three unit strings, then the four supply strings
	assign textFitted = {supplyState_r[2], supplyState_r[2],
		supplyState_r[0], supplyState_r[0], 3'b111};
	genvar g;
	generate
		for (g = 0; g < 7; g++)
		begin : gText
			bsr_text_cursor #(.LEN(TEXT_LEN)) uCursor (
				.clk(clk),
				.sys_rst(sys_rst),
				.text(g < 3 ? unitText[g % 3] : supplyText[(g + 1) % 4]), // both arms in range
				.fitted(textFitted[g]),
				.take(textTake[g]),
				.curByte(textByte[g])
			);
		end
	endgenerate

	// read decode; unmapped addresses answer zero
	always_comb
	begin
		readByte = 8'h00;
		textTake = 7'h00;
		unique case (bank_r)
			`BSR_BANK_CFG:
				unique case (inReq_r.data)
					`BSR_ADDR_PORT_CTRL: readByte = {4'h0, portBDisable_r, portADisable_r,
						portBSupplyOn_r, portASupplyOn_r};
					`BSR_ADDR_POLICY: readByte = {2'h0, firmwareSettingsWipe_r,
						processorPowerPolicy_r, 3'h0};
					`BSR_ADDR_BUTTON: readByte = {indicatorButtonFunction_r,
						recessedButtonFunction_r};
					`BSR_ADDR_TXT_SERIAL, `BSR_ADDR_TXT_PRODUCT_TYPE_TEXT, `BSR_ADDR_TXT_BUILD:
					begin
						readByte = textByte[inReq_r.data[1:0]];
						textTake[inReq_r.data[1:0]] = doRead;
					end
					`BSR_ADDR_EXP_LO: readByte = expansionFitted
						? expansionCode[7:0] : 8'(`BSR_EXP_ABSENT);
					`BSR_ADDR_EXP_HI: readByte = expansionFitted
						? expansionCode[15:8] : 8'(`BSR_EXP_ABSENT >> 8);
					default: readByte = 8'h00;
				endcase
			`BSR_BANK_DIAG:
				if (diagHit)
					readByte = inReq_r.data[1:0] == 2'h0 ? diagLive[diagIdx][7:0]
						: diagHeld_r[diagIdx][(inReq_r.data[1:0] - 2'h1)*8 +: 8];
			`BSR_BANK_TC:
				if (inReq_r.data[7:4] == 4'h0)
					readByte = inReq_r.data == `BSR_ADDR_TC_FIRST ? tcLive[0][7:0]
						: tcHeld_r[inReq_r.data[3:2]][inReq_r.data[1:0]*8 +: 8];
			`BSR_BANK_SUP:
				unique case (inReq_r.data)
					`BSR_ADDR_SUP1_STATE: readByte = {6'h0, supplyState_r[1:0]};
					`BSR_ADDR_SUP2_STATE: readByte = {6'h0, supplyState_r[3:2]};
					`BSR_ADDR_SUP1_PROD, `BSR_ADDR_SUP1_SER,
					`BSR_ADDR_SUP2_PROD, `BSR_ADDR_SUP2_SER:
					begin
						readByte = textByte[{1'b1, inReq_r.data[7], inReq_r.data[0]} - 3'h1];
						textTake[{1'b1, inReq_r.data[7], inReq_r.data[0]} - 3'h1] = doRead;
					end
					default: readByte = 8'h00;
				endcase
		endcase
	end

	// checks on the mailbox and the registers behind it
	sequence s_cfg_write(logic [7:0] a);
		doWrite && addr_r == a;
	endsequence

	a_read_answer: assert property (@(posedge clk) disable iff (sys_rst)
		doRead |=> outFull_r && outByte_r == $past(readByte))
		else $error("read answer not placed in output buffer");
	a_abort_idle: assert property (@(posedge clk) disable iff (sys_rst)
		proceed && inReq_r.isCmd && inReq_r.data == 8'h00 |=> mailboxState_r == bsr_pkg::BSR_IDLE)
		else $error("abort did not return mailbox to idle");
	a_port_disable: assert property (@(posedge clk) disable iff (sys_rst)
		s_cfg_write(8'h40) |=> portBDisable_r == $past(inReq_r.data[3])
		&& portADisable_r == $past(inReq_r.data[2]))
		else $error("port disable bits not taken");
	a_port_supply: assert property (@(posedge clk) disable iff (sys_rst)
		s_cfg_write(8'h40) |=> portBSupplyOn_r == $past(inReq_r.data[1])
		&& portASupplyOn_r == $past(inReq_r.data[0]))
		else $error("port supply bits not taken");
	a_wipe_request: assert property (@(posedge clk) disable iff (sys_rst)
		s_cfg_write(8'h42) |=> firmwareSettingsWipe_r == $past(inReq_r.data[5]))
		else $error("settings wipe bit not taken");
	a_policy_forced: assert property (@(posedge clk) disable iff (sys_rst)
		!policyWritable [*2] |-> processorPowerPolicy_r == 2'h1)
		else $error("locked policy not forced to keep running");
	a_policy_legal: assert property (@(posedge clk) disable iff (sys_rst)
		processorPowerPolicy_r != 2'h3)
		else $error("reserved power policy stored");
	a_watchdog_sticky: assert property (@(posedge clk) disable iff (sys_rst)
		watchdogExpired ##1 !sleepEntered |=> diagLive[12] != 32'h0)
		else $error("watchdog event lost");
	a_expansion_absent: assert property (@(posedge clk) disable iff (sys_rst)
		doRead && bank_r == 2'h0 && inReq_r.data == 8'h71 && !expansionFitted
		|=> outByte_r == 8'hFF)
		else $error("absent expansion card not read as all ones");
	a_tc_frozen: assert property (@(posedge clk) disable iff (sys_rst)
		!(doRead && bank_r == 2'h2 && inReq_r.data == 8'h00) |=> $stable(tcHeld_r))
		else $error("time-code capture changed without first-word read");
endmodule // bsr_supervisor_regs

// ### rtl/bsr_params.svh
// offsets, field positions, command codes and reset values of the supervisor banks
// assumes inclusion by bare name from the design files
`ifndef BSR_PARAMS_SVH
`define BSR_PARAMS_SVH

// mailbox command codes; low two bits pick the bank
`define BSR_CMD_ABORT 8'h00
`define BSR_CMD_WR_GRP 6'h04
`define BSR_CMD_RD_GRP 6'h08
`define BSR_BANK_CFG 2'h0
`define BSR_BANK_DIAG 2'h1
`define BSR_BANK_TC 2'h2
`define BSR_BANK_SUP 2'h3

// configuration bank
`define BSR_ADDR_PORT_CTRL 8'h40
`define BSR_ADDR_POLICY 8'h42
`define BSR_ADDR_BUTTON 8'h43
`define BSR_ADDR_TXT_SERIAL 8'h50
`define BSR_ADDR_TXT_PRODUCT_TYPE_TEXT 8'h51
`define BSR_ADDR_TXT_BUILD 8'h52
`define BSR_ADDR_EXP_LO 8'h70
`define BSR_ADDR_EXP_HI 8'h71
`define BSR_PORT_CTRL_RST 4'h0
`define BSR_POLICY_REG_RST 8'h10
`define BSR_BUTTON_RST 8'h12
`define BSR_PORT_B_DIS_BIT 3
`define BSR_PORT_A_DIS_BIT 2
`define BSR_PORT_B_PWR_BIT 1
`define BSR_PORT_A_PWR_BIT 0
`define BSR_WIPE_BIT 5
`define BSR_POLICY_LSB 3
`define BSR_BTN_LAMP 4'h1
`define BSR_BTN_POWER 4'h2
`define BSR_POLICY_KEEP 2'h1
`define BSR_POLICY_RSVD 2'h3
`define BSR_EXP_ABSENT 16'hFFFF

// health bank word offsets, in slot order
`define BSR_DIAG_COUNT 14
`define BSR_DIAG_OFFS {8'hE4, 8'hE0, 8'hDC, 8'hD8, 8'hD4, 8'hD0, 8'h6C, \
	8'h34, 8'h18, 8'h14, 8'h10, 8'h0C, 8'h04, 8'h00}

// time-code and supply banks
`define BSR_ADDR_TC_FIRST 8'h00
`define BSR_TC_GOOD_BIT 31
`define BSR_ADDR_SUP1_STATE 8'h00
`define BSR_ADDR_SUP1_PROD 8'h34
`define BSR_ADDR_SUP1_SER 8'h35
`define BSR_ADDR_SUP2_STATE 8'h80
`define BSR_ADDR_SUP2_PROD 8'hB4
`define BSR_ADDR_SUP2_SER 8'hB5

`endif

// ### rtl/bsr_pkg.sv
// types shared by the supervisor register banks
// assumes the params header for all numeric constants
package bsr_pkg;

	// mailbox state, codes as shown to the host
	typedef enum logic [1:0]
	{
		BSR_IDLE = 2'b00,
		BSR_WRITE = 2'b01,
		BSR_READ = 2'b10,
		BSR_ERROR = 2'b11
	} bsr_state_t;

	// one host write into the mailbox
	typedef struct packed
	{
		logic isCmd;
		logic [7:0] data;
	} bsr_host_wr_t;

	// decoded time message from the time-code receiver
	typedef struct packed
	{
		logic good;
		logic [6:0] hundredths;
		logic [25:0] secMinHour;
		logic [17:0] days;
		logic [26:0] control;
		logic [17:0] binarySec;
	} bsr_timecode_t;

endpackage

// ### rtl/bsr_text_cursor.sv
// byte-at-a-time reader of one zero-terminated ascii string
// assumes the text is stable while read; byte 0 is the first character
`timescale 1ns/1ns
module bsr_text_cursor #(
	parameter int LEN = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [LEN*8-1:0] text,
	input wire logic fitted,
	input wire logic take,
	output logic [7:0] curByte
);
	localparam int PW = $clog2(LEN + 1);
	logic [PW-1:0] ptr_r;

	// an absent source reads as zero; a string with no terminator reads zero after its last byte
	always_comb
	begin
		curByte = 8'h00;
		if (fitted && ptr_r < PW'(LEN))
			curByte = text[ptr_r*8 +: 8];
	end

	// zero byte rewinds the pointer
	always_ff @(posedge clk)
	begin
		if (sys_rst)
			ptr_r <= '0;
		else if (take)
			ptr_r <= (curByte == 8'h00) ? '0 : ptr_r + PW'(1);
	end

	a_text_rewind: assert property (@(posedge clk) disable iff (sys_rst)
		take && curByte == 8'h00 |=> ptr_r == '0)
		else $error("string pointer did not rewind after zero byte");
endmodule // bsr_text_cursor

// ### tb/bsr_host_product_type_text.sv
// host processor product_type_text: writes command, address and data bytes into the mailbox
// assumes the device drains each byte within 50 clk cycles
`timescale 1ns/1ns
module bsr_host_product_type_text (
	input wire logic clk,
	input wire logic inFull,
	input wire logic outFull,
	input wire logic [7:0] outByte,
	output bsr_pkg::bsr_host_wr_t hostWr,
	output logic hostWrite,
	output logic hostReadOut
);
	int bad;

	// idle host at time zero
	initial
	begin
		hostWr = '0;
		hostWrite = 1'b0;
		hostReadOut = 1'b0;
		bad = 0;
	end

	// one byte into the mailbox; the next byte waits until the input flag clears
	task automatic put(input logic isCmd, input logic [7:0] data);
		int n;
		@(negedge clk);
		hostWr = '{isCmd: isCmd, data: data};
		hostWrite = 1'b1;
		@(negedge clk);
		hostWrite = 1'b0;
		n = 0;
		while (inFull !== 1'b0 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 50)
			bad++;
	endtask

	// command, then address, then data; reserved bits come in as zero from the caller
	task automatic wr(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] d);
		put(1'b1, cmd);
		put(1'b0, a);
		put(1'b0, d);
	endtask

	// command, then address; the answer is taken once the output flag is up
	task automatic rd(input logic [7:0] cmd, input logic [7:0] a, output logic [7:0] val);
		int n;
		put(1'b1, cmd);
		put(1'b0, a);
		n = 0;
		while (outFull !== 1'b1 && n < 50)
		begin
			@(negedge clk);
			n++;
		end
		if (n == 50)
			bad++;
		val = outByte;
		hostReadOut = 1'b1;
		@(negedge clk);
		hostReadOut = 1'b0;
	endtask
endmodule // bsr_host_product_type_text

// ### tb/board_supervisor_register_maps_tb.sv
// self-checking bench for the supervisor register banks
// assumes the rtl package and the host product_type_text are compiled first
`timescale 1ns/1ns
module board_supervisor_register_maps_tb;
	logic clk, sys_rst, hostWrite, hostReadOut, outFull_r, inFull_r, lastWasCmd_r;
	logic expansionFitted, watchdogExpired, sleepEntered, firmwareSettingsWipe_r;
	logic [7:0] outByte_r, b;
	bsr_pkg::bsr_host_wr_t hostWr;
	bsr_pkg::bsr_state_t mailboxState_r;
	bsr_pkg::bsr_timecode_t timecode;
	logic [3:0] portBits, supplyPin, indicatorButtonFunction_r, recessedButtonFunction_r;
	logic [1:0] processorPowerPolicy_r;
	logic [2:0][31:0] unitText;
	logic [3:0][31:0] supplyText, wd, md;
	logic [15:0] expansionCode;
	logic [11:0][31:0] healthSample;
	logic [4:0] excessCurrent;
	logic [31:0] w;
	logic [7:0] offs [12];
	int failures, samples_checked;

	// short strings keep the text buses small
	bsr_supervisor_regs #(.TEXT_LEN(4)) dut (.clk, .sys_rst, .hostWrite, .hostWr,
		.hostReadOut, .outByte_r, .outFull_r, .inFull_r, .lastWasCmd_r, .mailboxState_r,
		.portBDisable_r(portBits[3]), .portADisable_r(portBits[2]),
		.portBSupplyOn_r(portBits[1]), .portASupplyOn_r(portBits[0]),
		.firmwareSettingsWipe_r, .processorPowerPolicy_r, .indicatorButtonFunction_r,
		.recessedButtonFunction_r, .unitText, .supplyText, .supplyPin, .expansionCode,
		.expansionFitted, .healthSample, .watchdogExpired, .sleepEntered, .excessCurrent,
		.timecode);

	bsr_host_product_type_text hm (.clk, .inFull(inFull_r), .outFull(outFull_r), .outByte(outByte_r),
		.hostWr, .hostWrite, .hostReadOut);

	// 25 MHz clock
	initial
		clk = 1'b0;
	always #20 clk = ~clk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// reserved bits may read anything, so only masked bits are compared
	task automatic rdchk(input logic [7:0] cmd, input logic [7:0] a, input logic [7:0] exp,
		input logic [7:0] m);
		hm.rd(cmd, a, b);
		chk(b & m, exp & m);
	endtask

	// four bytes of one little-endian word, lowest first so it is captured
	task automatic rd32(input logic [7:0] cmd, input logic [7:0] a);
		for (int k = 0; k < 4; k++)
		begin
			hm.rd(cmd, a + 8'(k), b);
			w[8*k+:8] = b;
		end
	endtask

	task automatic results;
		failures += hm.bad;
		$display("failures=%0d samples_checked=%0d", failures, samples_checked);
		if (failures == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// watchdog: about a thousand cycles are expected, thirty times that is a hang
	initial
	begin
		#(40 * 30000);
		failures++;
		results();
	end

	// main sequence
	initial
	begin
		failures = 0;
		samples_checked = 0;
		sys_rst = 1'b1;
		expansionCode = '0;
		expansionFitted = 1'b0;
		watchdogExpired = 1'b0;
		sleepEntered = 1'b0;
		excessCurrent = '0;
		supplyPin = '0;
		supplyText = {32'h53, 32'h51, 32'h54, 32'h50};
		timecode = '{good: 1'b1, hundredths: 7'h63, secMinHour: 26'h2ABCDEF,
			days: 18'h25A5A, control: 27'h5A5A5A5, binarySec: 18'h12345};
		for (int i = 0; i < 12; i++)
			healthSample[i] = 32'h1020_3040 + 32'(i);
		for (int s = 0; s < 3; s++)
			unitText[s] = 32'h0000_4241 + 32'h0101 * s;
		offs = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h34, 8'h6C, 8'hD0, 8'hD4,
			8'hD8, 8'hDC};
		repeat (2) @(negedge clk);
		sys_rst = 1'b0;
		// reset values of the configuration registers
		rdchk(8'h20, 8'h40, 8'h00, 8'h0F);
		rdchk(8'h20, 8'h42, 8'h10, 8'h38);
		rdchk(8'h20, 8'h43, 8'h12, 8'hFF);
		for (int i = 0; i < 2; i++)
		begin
			hm.wr(8'h10, 8'h40, {4'h0, 4'hA >> i});
			chk(portBits, 4'hA >> i);
			rdchk(8'h20, 8'h40, {4'h0, 4'hA >> i}, 8'h0F);
		end
		// every policy code; the reserved one leaves the last setting
		for (int p = 0; p < 4; p++)
		begin
			hm.wr(8'h10, 8'h42, {2'b00, 1'b1, 2'(p), 3'b000});
			chk(firmwareSettingsWipe_r, 1'b1);
			chk(processorPowerPolicy_r, (p == 3) ? 2'h2 : 2'(p));
		end
		// every button code; policy locked unless a button is power or lamp test
		for (int c = 0; c < 4; c++)
		begin
			hm.wr(8'h10, 8'h43, {2{4'(c)}});
			chk({indicatorButtonFunction_r, recessedButtonFunction_r}, {2{4'(c)}});
			hm.wr(8'h10, 8'h42, 8'h00);
			chk(processorPowerPolicy_r, (c == 1 || c == 2) ? 2'h0 : 2'h1);
		end
		rdchk(8'h20, 8'h42, 8'h08, 8'h18);
		hm.wr(8'h10, 8'h43, 8'h20);
		hm.wr(8'h10, 8'h42, 8'h10);
		chk(processorPowerPolicy_r, 2'h2);
		// strings end in zero and start over
		for (int s = 0; s < 3; s++)
			for (int k = 0; k < 4; k++)
				rdchk(8'h20, 8'h50 + 8'(s), (k == 2) ? 8'h00 : 8'h41 + 8'(s) + 8'(k % 3),
					8'hFF);
		expansionCode = 16'h1234;
		expansionFitted = 1'b1;
		rdchk(8'h20, 8'h70, 8'h34, 8'hFF);
		rdchk(8'h20, 8'h71, 8'h12, 8'hFF);
		expansionFitted = 1'b0;
		rdchk(8'h20, 8'h70, 8'hFF, 8'hFF);
		rdchk(8'h20, 8'h71, 8'hFF, 8'hFF);
		// unmapped address, then a stray data byte and the abort that clears it
		rdchk(8'h20, 8'h7F, 8'h00, 8'hFF);
		hm.put(1'b0, 8'h55);
		chk(mailboxState_r, 2'h3);
		chk(lastWasCmd_r, 1'b0);
		hm.put(1'b1, 8'h00);
		chk(mailboxState_r, 2'h0);
		chk(lastWasCmd_r, 1'b1);
		// a write into the health bank is taken and ignored
		hm.wr(8'h11, 8'h40, 8'h0F);
		chk(portBits, 4'h5);
		chk(mailboxState_r, 2'h0);
		// health words: upper bytes come from the capture, not the live value
		for (int i = 0; i < 12; i++)
		begin
			rdchk(8'h21, offs[i], 8'h40 + 8'(i), 8'hFF);
			healthSample[i] = 32'hFFFF_FFFF;
			for (int k = 1; k < 4; k++)
				rdchk(8'h21, offs[i] + 8'(k), 8'h40 - 8'h10 * 8'(k), 8'hFF);
		end
		rdchk(8'h21, 8'h00, 8'hFF, 8'hFF);
		rdchk(8'h21, 8'h03, 8'hFF, 8'hFF);
		rd32(8'h21, 8'hE0);
		chk(w != 32'h0, 1'b0);
		watchdogExpired = 1'b1;
		@(negedge clk);
		watchdogExpired = 1'b0;
		rd32(8'h21, 8'hE0);
		chk(w != 32'h0, 1'b1);
		sleepEntered = 1'b1;
		@(negedge clk);
		sleepEntered = 1'b0;
		rd32(8'h21, 8'hE0);
		chk(w != 32'h0, 1'b0);
		excessCurrent = 5'h15;
		rd32(8'h21, 8'hE4);
		chk(w, 32'h15);
		// time-code words built from the field layout; input cleared after capture
		wd = {{timecode.good, 13'h0, timecode.binarySec}, {timecode.good, 4'h0, timecode.control},
			{timecode.good, timecode.hundredths, 6'h0, timecode.days},
			{timecode.good, 5'h0, timecode.secMinHour}};
		md = {32'h8003_FFFF, 32'h87FF_FFFF, 32'hFF03_FFFF, 32'h83FF_FFFF};
		for (int k = 0; k < 16; k++)
		begin
			if (k == 1)
				timecode = '0;
			rdchk(8'h22, 8'(k), 8'(wd[k/4] >> (8 * (k % 4))),
				8'(md[k/4] >> (8 * (k % 4))));
		end
		rdchk(8'h22, 8'h00, 8'h00, 8'hFF);
		rdchk(8'h22, 8'h07, 8'h00, 8'h80);
		// supply pins pass a synchroniser, so let them settle
		supplyPin = 4'b0111;
		repeat (8) @(negedge clk);
		rdchk(8'h23, 8'h00, 8'h03, 8'h03);
		rdchk(8'h23, 8'h80, 8'h01, 8'h03);
		rdchk(8'h23, 8'h34, 8'h50, 8'hFF);
		rdchk(8'h23, 8'h34, 8'h00, 8'hFF);
		rdchk(8'h23, 8'hB5, 8'h53, 8'hFF);
		supplyPin = 4'b1100;
		repeat (8) @(negedge clk);
		rdchk(8'h23, 8'h00, 8'h00, 8'h03);
		rdchk(8'h23, 8'h80, 8'h03, 8'h03);
		rdchk(8'h23, 8'h35, 8'h00, 8'hFF);
		rdchk(8'h23, 8'hB4, 8'h51, 8'hFF);
		results();
	end
endmodule // board_supervisor_register_maps_tb
